/* logic/mgmt_mode_entry_exit_state.sv */
`timescale 1ns/1ps
module mgmt_mode_entry_exit_state (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mgmt_interrupt,
  input wire logic resume_from_mgmt,
  input wire logic interrupt_return,
  input wire logic nmi_request,
  input wire logic nmi_block_req,
  input wire logic halted,
  input wire logic halt_cached,
  input wire logic io_last_ok,
  input wire mgmt_pkg::io_kind_e io_kind,
  input wire mgmt_pkg::io_size_e io_size,
  input wire logic [15:0] io_port,
  input wire logic [31:0] io_mem_addr,
  input wire logic fpu_mode_switched,
  input wire logic map_rd,
  input wire logic map_wr,
  input wire logic [15:0] map_addr,
  input wire logic [15:0] map_wdata,
  output logic [31:0] map_rdata,
  output logic in_mgmt,
  output logic nmi_service,
  output logic resume_to_halt,
  output logic resume_next,
  output logic halt_fetch,
  output logic halt_bus_cycle,
  output logic fpu_real16_layout
);
  import mgmt_pkg::*;

  // ------------------------------------------------------------
  // constants and encoders
  // ------------------------------------------------------------
  // base and flags
  localparam logic [31:0] REV_WORD =
    {14'h0000, HAS_RELOC, HAS_IO_RESTART, REV_BASE};
  localparam logic IO_PRESENT = (REV_WORD >= REV_THRESHOLD);

  function automatic logic [3:0] enc_type(input io_kind_e k);
    logic [3:0] t;
    t = TYPE_OUT_DX;
    unique case (k)
      io_in_imm: t = TYPE_IN_IMM;
      io_in_dx: t = TYPE_IN_DX;
      io_out_imm: t = TYPE_OUT_IMM;
      io_out_dx: t = TYPE_OUT_DX;
      io_str_in: t = TYPE_STR_IN;
      io_str_out: t = TYPE_STR_OUT;
      io_rep_in: t = TYPE_REP_IN;
      io_rep_out: t = TYPE_REP_OUT;
    endcase
    return t;
  endfunction

  function automatic logic [2:0] enc_len(input io_size_e s);
    logic [2:0] l;
    l = LEN_BYTE;
    case (s)
      sz_word: l = LEN_WORD;
      sz_dword: l = LEN_DWORD;
      default: l = LEN_BYTE;
    endcase
    return l;
  endfunction

  // ------------------------------------------------------------
  // state and decodes
  // ------------------------------------------------------------
  state_e st, next_st;
  logic nmi_pending, nmi_mask, nmi_by_handler, keep_block, mgmt_nmi_open;
  logic halt_flag, io_valid;
  logic [15:0] io_port_q;
  logic [3:0] io_type_q;
  logic [2:0] io_len_q;
  logic [31:0] io_addr_q;

  wire entry_take = (st == st_run) && mgmt_interrupt;
  wire resume_take = (st == st_mgmt) && resume_from_mgmt;
  wire in_exit = (st == st_exit);
  wire interrupt_return_mgmt = (st == st_mgmt) && interrupt_return;
  wire interrupt_return_run = (st == st_run) && interrupt_return;
  wire trap_hit = IO_PRESENT && io_last_ok;
  wire halt_wr = (st == st_mgmt) && map_wr && (map_addr == OFS_HALT);

  wire nmi_blocked = (st == st_mgmt) ? !mgmt_nmi_open :
                     in_exit ? keep_block : nmi_mask;
  wire svc = nmi_pending && !nmi_blocked && !entry_take;

  wire [31:0] io_state_word = IO_PRESENT ?
    {io_port_q, 8'h00, io_type_q, io_len_q, io_valid} : RST_WORD;
  wire [31:0] io_addr_word = IO_PRESENT ? io_addr_q : RST_WORD;
  wire [31:0] halt_word = {31'h0000_0000, halt_flag};
  wire [31:0] rd_word =
    (map_addr == OFS_REVISION) ? REV_WORD :
    (map_addr == OFS_HALT) ? halt_word :
    (map_addr == OFS_IO_ADDR) ? io_addr_word :
    (map_addr == OFS_IO_STATE) ? io_state_word : RST_WORD;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    unique case (st)
      st_run: if (mgmt_interrupt) next_st = st_mgmt;
      st_mgmt: if (resume_from_mgmt) next_st = st_exit;
      st_exit: next_st = st_run;
      default: next_st = st_run;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) st <= st_run;
    else st <= next_st;
  end

  // ------------------------------------------------------------
  // nmi latch and blocking
  // ------------------------------------------------------------
  // single pending latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) nmi_pending <= 1'b0;
    else nmi_pending <= (nmi_pending && !svc) || nmi_request;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_mask <= 1'b0;
      nmi_by_handler <= 1'b0;
    end else if (svc) begin
      nmi_mask <= 1'b1;
      nmi_by_handler <= 1'b1;
    end else if (in_exit) begin
      nmi_mask <= keep_block;
      nmi_by_handler <= 1'b0;
    end else if (interrupt_return_run) begin
      nmi_mask <= 1'b0;
      nmi_by_handler <= 1'b0;
    end else if ((st == st_run) && nmi_block_req) begin
      nmi_mask <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) keep_block <= 1'b0;
    else if (entry_take) keep_block <= nmi_mask && !nmi_by_handler;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) mgmt_nmi_open <= 1'b0;
    else if (entry_take) mgmt_nmi_open <= 1'b0;
    else if (svc && (st == st_mgmt)) mgmt_nmi_open <= 1'b0;
    else if (interrupt_return_mgmt) mgmt_nmi_open <= 1'b1;
  end

  // ------------------------------------------------------------
  // save-map capture
  // ------------------------------------------------------------
  // halt flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) halt_flag <= 1'b0;
    else if (entry_take) halt_flag <= halted;
    else if (halt_wr) halt_flag <= map_wdata[HALT_FLAG_BIT];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) io_valid <= 1'b0;
    else if (entry_take) io_valid <= trap_hit;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_port_q <= 16'h0000;
      io_type_q <= 4'h0;
      io_len_q <= 3'h0;
      io_addr_q <= RST_WORD;
    end else if (entry_take && trap_hit) begin
      io_port_q <= io_port;
      io_type_q <= enc_type(io_kind);
      io_len_q <= enc_len(io_size);
      io_addr_q <= io_mem_addr;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) map_rdata <= RST_WORD;
    else if (map_rd) map_rdata <= rd_word;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign in_mgmt = (st == st_mgmt);
  assign nmi_service = svc;
  assign resume_to_halt = in_exit && halt_flag;
  assign resume_next = in_exit && !halt_flag;
  assign halt_fetch = resume_to_halt && !halt_cached;
  assign halt_bus_cycle = resume_to_halt;
  assign fpu_real16_layout = in_mgmt && !fpu_mode_switched;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_resume_halt;
    (st == st_mgmt) && resume_from_mgmt && halt_flag && !halt_wr;
  endsequence
  sequence s_halt_out;
    resume_to_halt && !resume_next ##1 (st == st_run);
  endsequence

  property p_valid_cause;
    entry_take |=> (io_valid == (IO_PRESENT && $past(io_last_ok)));
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("trap valid does not follow io success");
  property p_valid_clear;
    entry_take && !io_last_ok |=> !io_valid ##1 $stable(io_valid);
  endproperty
  a_valid_clear: assert property (p_valid_clear)
    else $error("trap valid not cleared on plain entry");
  property p_port_store;
    entry_take && trap_hit |=> io_port_q == $past(io_port);
  endproperty
  a_port_store: assert property (p_port_store)
    else $error("trapped port not stored");
  property p_state_read;
    map_rd && (map_addr == OFS_IO_STATE) |=>
      map_rdata[IO_VALID_BIT] == $past(io_valid) &&
      map_rdata[15:8] == 8'h00;
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("io state word read wrong");
  property p_len_dword;
    entry_take && trap_hit && (io_size == sz_dword) |=> io_len_q == LEN_DWORD;
  endproperty
  a_len_dword: assert property (p_len_dword)
    else $error("dword length code wrong");
  property p_type_rep_in;
    entry_take && trap_hit && (io_kind == io_rep_in) |=> io_type_q == TYPE_REP_IN;
  endproperty
  a_type_rep_in: assert property (p_type_rep_in)
    else $error("repeated input type code wrong");
  property p_block_in_mgmt;
    (st == st_mgmt) && !mgmt_nmi_open |-> !nmi_service;
  endproperty
  a_block_in_mgmt: assert property (p_block_in_mgmt)
    else $error("nmi served while blocked in management mode");

  property p_exit_serve;
    in_exit && nmi_pending && !keep_block |-> nmi_service ##1 nmi_mask;
  endproperty
  a_exit_serve: assert property (p_exit_serve)
    else $error("pending nmi not served at resume");

  property p_exit_keep;
    in_exit && keep_block |-> !nmi_service ##1 nmi_mask;
  endproperty
  a_exit_keep: assert property (p_exit_keep)
    else $error("nmi block lost across resume");

  property p_interrupt_return_open;
    interrupt_return_mgmt && !svc |=> mgmt_nmi_open;
  endproperty
  a_interrupt_return_open: assert property (p_interrupt_return_open)
    else $error("interrupt return did not unblock nmi");

  property p_rev_read;
    map_rd && (map_addr == OFS_REVISION) |=> map_rdata == REV_WORD;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision word read wrong");

  property p_halt_entry;
    entry_take |=> halt_flag == $past(halted);
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt flag not captured on entry");

  property p_halt_resume;
    s_resume_halt |=> s_halt_out;
  endproperty
  a_halt_resume: assert property (p_halt_resume)
    else $error("resume did not return to halt");

  property p_halt_fetch;
    s_resume_halt |=> halt_bus_cycle && (halt_fetch == !halt_cached);
  endproperty
  a_halt_fetch: assert property (p_halt_fetch)
    else $error("halt restart missing fetch or bus cycle");

  property p_fpu_layout;
    (st == st_mgmt) && !fpu_mode_switched |-> fpu_real16_layout;
  endproperty
  a_fpu_layout: assert property (p_fpu_layout)
    else $error("real layout not selected in management mode");

endmodule

/* logic/mgmt_pkg.sv */
package mgmt_pkg;

  // ------------------------------------------------------------
  // save-map offsets and field positions
  // ------------------------------------------------------------
  localparam logic [15:0] OFS_REVISION = 16'h7EFC;
  localparam logic [15:0] OFS_HALT = 16'h7F02;
  localparam logic [15:0] OFS_IO_ADDR = 16'h7FA0;
  localparam logic [15:0] OFS_IO_STATE = 16'h7FA4;
  localparam int IO_VALID_BIT = 0;
  localparam int IO_LEN_LSB = 1;
  localparam int IO_TYPE_LSB = 4;
  localparam int IO_PORT_LSB = 16;
  localparam int HALT_FLAG_BIT = 0;
  localparam int REV_RESTART_BIT = 16;
  localparam int REV_RELOC_BIT = 17;

  // ------------------------------------------------------------
  // revision word; values are arbitrary
  // ------------------------------------------------------------
  localparam logic [15:0] REV_BASE = 16'h0002;
  localparam logic [31:0] REV_THRESHOLD = 32'h0000_0002;
  localparam logic HAS_IO_RESTART = 1'b0;
  localparam logic HAS_RELOC = 1'b0;

  // ------------------------------------------------------------
  // field encodings and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_DWORD = 3'h4;
  localparam logic [3:0] TYPE_IN_IMM = 4'h9;
  localparam logic [3:0] TYPE_IN_DX = 4'h1;
  localparam logic [3:0] TYPE_OUT_IMM = 4'h8;
  localparam logic [3:0] TYPE_OUT_DX = 4'h0;
  localparam logic [3:0] TYPE_STR_IN = 4'h3;
  localparam logic [3:0] TYPE_STR_OUT = 4'h2;
  localparam logic [3:0] TYPE_REP_IN = 4'h7;
  localparam logic [3:0] TYPE_REP_OUT = 4'h6;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    io_in_imm, io_in_dx, io_out_imm, io_out_dx,
    io_str_in, io_str_out, io_rep_in, io_rep_out
  } io_kind_e;
  typedef enum logic [1:0] {sz_byte, sz_word, sz_dword} io_size_e;
  typedef enum logic [1:0] {
    st_run = 2'b00, st_mgmt = 2'b01, st_exit = 2'b11
  } state_e;

endpackage

/* bench/test_mgmt_mode_entry_exit_state.sv */
`timescale 1ns/1ps
module test_mgmt_mode_entry_exit_state;
  import mgmt_pkg::*;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mgmt_interrupt = 1'b0;
  logic resume_from_mgmt = 1'b0;
  logic interrupt_return = 1'b0;
  logic nmi_request = 1'b0;
  logic nmi_block_req = 1'b0;
  logic halted = 1'b0;
  logic halt_cached = 1'b1;
  logic io_last_ok = 1'b0;
  io_kind_e io_kind = io_in_imm;
  io_size_e io_size = sz_byte;
  logic [15:0] io_port = 16'h0000;
  logic [31:0] io_mem_addr = 32'h0000_0000;
  logic fpu_mode_switched = 1'b0;
  logic map_rd = 1'b0;
  logic map_wr = 1'b0;
  logic [15:0] map_addr = 16'h0000;
  logic [15:0] map_wdata = 16'h0000;
  logic [31:0] map_rdata;
  logic in_mgmt;
  logic nmi_service;
  logic resume_to_halt;
  logic resume_next;
  logic halt_fetch;
  logic halt_bus_cycle;
  logic fpu_real16_layout;
  int fail_count = 0;
  int n_compared = 0;
  int nmi_cnt = 0;
  int base;
  logic [4:0] ex;
  logic [3:0] type_code [8] = '{4'h9, 4'h1, 4'h8, 4'h0, 4'h3, 4'h2, 4'h7, 4'h6};
  logic [2:0] len_code [3] = '{3'h1, 3'h2, 3'h4};

  mgmt_mode_entry_exit_state i_mgmt_mode_entry_exit_state (
    .clk(clk), .sys_rst(sys_rst), .mgmt_interrupt(mgmt_interrupt),
    .resume_from_mgmt(resume_from_mgmt), .interrupt_return(interrupt_return),
    .nmi_request(nmi_request), .nmi_block_req(nmi_block_req), .halted(halted),
    .halt_cached(halt_cached), .io_last_ok(io_last_ok), .io_kind(io_kind),
    .io_size(io_size), .io_port(io_port), .io_mem_addr(io_mem_addr),
    .fpu_mode_switched(fpu_mode_switched), .map_rd(map_rd), .map_wr(map_wr),
    .map_addr(map_addr), .map_wdata(map_wdata), .map_rdata(map_rdata),
    .in_mgmt(in_mgmt), .nmi_service(nmi_service), .resume_to_halt(resume_to_halt),
    .resume_next(resume_next), .halt_fetch(halt_fetch),
    .halt_bus_cycle(halt_bus_cycle), .fpu_real16_layout(fpu_real16_layout)
  );

  always #5 clk = ~clk;

  // counts nmi service pulses seen at each rising edge
  always @(posedge clk) begin
    if (nmi_service === 1'b1) nmi_cnt <= nmi_cnt + 1;
  end

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic enter();
    mgmt_interrupt = 1'b1;
    tick();
    mgmt_interrupt = 1'b0;
    check(in_mgmt, 1'b1);
  endtask

  task automatic resume(output logic [4:0] pulses);
    resume_from_mgmt = 1'b1;
    tick();
    resume_from_mgmt = 1'b0;
    pulses = {in_mgmt, resume_to_halt, resume_next, halt_fetch, halt_bus_cycle};
    tick();
  endtask

  task automatic rd(input logic [15:0] a);
    map_rd = 1'b1;
    map_addr = a;
    tick();
    map_rd = 1'b0;
    tick();
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    map_wr = 1'b1;
    map_addr = a;
    map_wdata = d;
    tick();
    map_wr = 1'b0;
  endtask

  task automatic nmi_pulse();
    nmi_request = 1'b1;
    tick();
    nmi_request = 1'b0;
  endtask

  task automatic interrupt_return_pulse();
    interrupt_return = 1'b1;
    tick();
    interrupt_return = 1'b0;
  endtask

  task automatic test_done();
    $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    fail_count++;
    test_done();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    tick(16);
    check({map_rdata[0], in_mgmt, nmi_service, resume_to_halt}, 32'h0);
    sys_rst = 1'b0;
    tick();
    io_last_ok = 1'b1;
    for (int k = 0; k < 8; k++) begin
      io_kind = io_kind_e'(k);
      io_size = io_size_e'(k % 3);
      io_port = 16'hA5C3 ^ 16'(k);
      io_mem_addr = 32'h1234_5678 + 32'(k);
      enter();
      rd(OFS_IO_STATE);
      check(map_rdata, {io_port, 8'h00, type_code[k], len_code[k % 3], 1'b1});
      rd(OFS_IO_ADDR);
      check(map_rdata, io_mem_addr);
      rd(OFS_REVISION);
      check(map_rdata, {14'h0, HAS_RELOC, HAS_IO_RESTART, REV_BASE});
      check(fpu_real16_layout, 1'b1);
      rd(OFS_HALT);
      check(map_rdata, 32'h0);
      resume(ex);
      check(ex, 5'b00100);
    end
    io_last_ok = 1'b0;
    fpu_mode_switched = 1'b1;
    enter();
    rd(OFS_IO_STATE);
    check(map_rdata[0], 1'b0);
    check(fpu_real16_layout, 1'b0);
    rd(16'h7F10);
    check(map_rdata, 32'h0);
    resume(ex);
    fpu_mode_switched = 1'b0;
    halted = 1'b1;
    halt_cached = 1'b0;
    enter();
    halted = 1'b0;
    rd(OFS_HALT);
    check(map_rdata, 32'h1);
    resume(ex);
    check(ex, 5'b01011);
    halted = 1'b1;
    halt_cached = 1'b1;
    enter();
    halted = 1'b0;
    wr(OFS_HALT, 16'h0000);
    rd(OFS_HALT);
    check(map_rdata, 32'h0);
    resume(ex);
    check(ex, 5'b00100);
    base = nmi_cnt;
    enter();
    nmi_pulse();
    tick();
    nmi_pulse();
    tick(3);
    check(nmi_cnt - base, 0);
    resume(ex);
    check(nmi_cnt - base, 1);
    tick(3);
    check(nmi_cnt - base, 1);
    interrupt_return_pulse();
    tick(2);
    check(nmi_cnt - base, 1);
    enter();
    interrupt_return_pulse();
    nmi_pulse();
    tick(2);
    check(nmi_cnt - base, 2);
    resume(ex);
    interrupt_return_pulse();
    nmi_pulse();
    tick(2);
    check(nmi_cnt - base, 3);
    enter();
    nmi_pulse();
    resume(ex);
    check(nmi_cnt - base, 4);
    interrupt_return_pulse();
    tick();
    interrupt_return_pulse();
    tick(2);
    nmi_block_req = 1'b1;
    tick();
    nmi_block_req = 1'b0;
    enter();
    nmi_pulse();
    resume(ex);
    tick(3);
    check(nmi_cnt - base, 4);
    test_done();
  end
endmodule
